//--- rtl/loop_fault_defines.svh
// timing counts, thresholds and blank display value of the loop fault block
`ifndef LOOP_FAULT_DEFINES_SVH
`define LOOP_FAULT_DEFINES_SVH

`define CLK_KHZ 50000
`define TIMER_W 28
`define DELAY_MS 2000
`define RETUNE_MS 2000
`define RECALL_MS 2000
`define OUTAGE_MS 3000
`define FREQ_SHOW_MS 2000
`define BLINK_HZ 2
`define BLINK_HALF_MS (1000 / (2 * `BLINK_HZ))
`define FLASH_ON_MS 250
`define FLASH_OFF_MS 250
`define FLASH_PAUSE_MS 1500
`define CHANGE_LIMIT_PCT 8'h19
`define DISP_BLANK 8'h00

`endif

//--- rtl/loop_fault_pkg.sv
// types shared by the loop fault block
package loop_fault_pkg;

    // order matters: the position is the flash count
    typedef enum logic [1:0] {
        FAULT_NONE,
        FAULT_OPEN,
        FAULT_SHORT,
        FAULT_CHANGE
    } fault_e;

    typedef enum logic [1:0] {
        DISP_NORMAL,
        DISP_FAULT,
        DISP_FREQ,
        DISP_DELAY
    } disp_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ON,
        SEQ_OFF,
        SEQ_PAUSE
    } seq_state_e;

    typedef struct packed {
        logic open_loop;
        logic short_loop;
        logic change_valid;
        logic [7:0] change_pct;
    } loop_status_s;

    typedef struct packed {
        disp_mode_e mode;
        logic [7:0] value;
    } display_s;

endpackage

//--- rtl/hold_timer.sv
// counter that reports when its run input has been high for LIMIT cycles
`timescale 1ns/100ps
`include "loop_fault_defines.svh"

module hold_timer #(
    parameter int unsigned LIMIT = 1
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // control
    input wire logic i_run,
    output logic o_done
);
    logic [`TIMER_W-1:0] count;
    logic [`TIMER_W-1:0] next_count;

    always_comb begin
        if (!i_run) begin
            next_count = '0;
        end else if (count != LIMIT[`TIMER_W-1:0]) begin
            next_count = count + `TIMER_W'(1);
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_done = (count == LIMIT[`TIMER_W-1:0]);

    a_stop_clears: assert property (@(posedge i_clock) disable iff (i_reset)
        !i_run |=> !o_done)
        else $error("timer done without run");
endmodule

//--- rtl/flash_sequencer.sv
// repeats a group of lamp flashes, one per count, with a pause between groups
`timescale 1ns/100ps
`include "loop_fault_defines.svh"

module flash_sequencer #(
    parameter int unsigned ON_CYCLES = 1,
    parameter int unsigned OFF_CYCLES = 1,
    parameter int unsigned PAUSE_CYCLES = 1
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // pattern
    input wire logic [1:0] i_flashes,
    output logic o_lamp
);
    loop_fault_pkg::seq_state_e state;
    loop_fault_pkg::seq_state_e next_state;
    logic [`TIMER_W-1:0] timer;
    logic [`TIMER_W-1:0] next_timer;
    logic [1:0] left;
    logic [1:0] next_left;

    always_comb begin
        next_state = state;
        next_timer = (timer != '0) ? timer - `TIMER_W'(1) : timer;
        next_left = left;
        if (i_flashes == 2'h0) begin
            next_state = loop_fault_pkg::SEQ_IDLE;
        end else begin
            case (state)
                loop_fault_pkg::SEQ_IDLE: begin
                    next_state = loop_fault_pkg::SEQ_ON;
                    next_timer = ON_CYCLES[`TIMER_W-1:0] - `TIMER_W'(1);
                    next_left = i_flashes;
                end
                loop_fault_pkg::SEQ_ON: begin
                    if (timer == '0) begin
                        next_state = loop_fault_pkg::SEQ_OFF;
                        next_timer = OFF_CYCLES[`TIMER_W-1:0] - `TIMER_W'(1);
                    end
                end
                loop_fault_pkg::SEQ_OFF: begin
                    // readable count needs a long dark gap after the last flash [R18]
                    if (timer == '0 && left == 2'h1) begin
                        next_state = loop_fault_pkg::SEQ_PAUSE;
                        next_timer = PAUSE_CYCLES[`TIMER_W-1:0] - `TIMER_W'(1);
                    end else if (timer == '0) begin
                        next_state = loop_fault_pkg::SEQ_ON;
                        next_timer = ON_CYCLES[`TIMER_W-1:0] - `TIMER_W'(1);
                        next_left = left - 2'h1;
                    end
                end
                loop_fault_pkg::SEQ_PAUSE: begin
                    if (timer == '0) begin
                        next_state = loop_fault_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    next_state = loop_fault_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state <= loop_fault_pkg::SEQ_IDLE;
            timer <= '0;
            left <= 2'h0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            left <= next_left;
        end
    end

    assign o_lamp = (state == loop_fault_pkg::SEQ_IDLE) || (state == loop_fault_pkg::SEQ_ON);

    a_pause_dark: assert property (@(posedge i_clock) disable iff (i_reset)
        (state == loop_fault_pkg::SEQ_OFF && timer == '0 && left == 2'h1
            && i_flashes != 2'h0)
        |=> !o_lamp && state == loop_fault_pkg::SEQ_PAUSE) // [R18]
        else $error("no pause after flash group");
endmodule

//--- rtl/loop_fault_indication_memory.sv
// loop fault supervision, lamp and display indication, fault memory and call hold
//
// What this block does
// R1 - detect lamp steady while vehicle detected
// R2 - detect lamp blinks 2 Hz during delay
// R3 - second output has no status lamp
// R4 - fault on open, short, change over 25%
// R5 - live fault: both lamps flash, display code
// R6 - one, two, three flashes by fault type
// R7 - healed fault: power lamp keeps last pattern
// R8 - retune two seconds after inductance change
// R9 - button press resets, clears flashing, shows frequency
// R10 - two second hold recalls stored fault
// R11 - last fault kept in non-volatile store
// R12 - power-up shows stored status on power lamp
// R13 - momentary press clears stored fault record
// R14 - call held across outage up to 3 s
// R15 - tune automatically at power-up
// R16 - delay option: outputs off 2 s after entry
// R17 - fail-safe asserts presence during loop fault
// R18 - pause between repeated flash groups
`timescale 1ns/100ps
`include "loop_fault_defines.svh"

module loop_fault_indication_memory #(
    parameter int unsigned DELAY_CYCLES = `DELAY_MS * `CLK_KHZ,
    parameter int unsigned RETUNE_CYCLES = `RETUNE_MS * `CLK_KHZ,
    parameter int unsigned RECALL_CYCLES = `RECALL_MS * `CLK_KHZ,
    parameter int unsigned OUTAGE_CYCLES = `OUTAGE_MS * `CLK_KHZ,
    parameter int unsigned FREQ_SHOW_CYCLES = `FREQ_SHOW_MS * `CLK_KHZ,
    parameter int unsigned BLINK_CYCLES = `BLINK_HALF_MS * `CLK_KHZ,
    parameter int unsigned FLASH_ON_CYCLES = `FLASH_ON_MS * `CLK_KHZ,
    parameter int unsigned FLASH_OFF_CYCLES = `FLASH_OFF_MS * `CLK_KHZ,
    parameter int unsigned FLASH_PAUSE_CYCLES = `FLASH_PAUSE_MS * `CLK_KHZ
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // loop measurement
    input wire logic i_vehicle,
    input wire loop_fault_pkg::loop_status_s i_loop,
    input wire logic [7:0] i_loop_freq_khz,
    // configuration switches, panel button and supply monitor
    input wire logic i_delay_enable,
    input wire logic i_fail_safe,
    input wire logic i_button,
    input wire logic i_power_good,
    // non-volatile fault store
    input wire logic [1:0] i_nv_code,
    output logic o_nv_we,
    output logic [1:0] o_nv_code,
    // outputs and indicators
    output logic o_presence,
    output logic o_detect_lamp,
    output logic o_power_lamp,
    output loop_fault_pkg::display_s o_display,
    output logic o_retune
);
    logic boot;
    logic change_latched;
    logic call;
    logic show_mem;
    logic recall;
    logic recall_taken;
    logic freq_show;
    logic btn_prev;
    logic blink;
    loop_fault_pkg::fault_e last_fault;
    loop_fault_pkg::fault_e prev_live;
    logic next_boot;
    logic next_change_latched;
    logic next_call;
    logic next_show_mem;
    logic next_recall;
    logic next_recall_taken;
    logic next_freq_show;
    logic next_blink;
    loop_fault_pkg::fault_e next_last_fault;
    logic next_nv_we;
    logic [1:0] next_nv_code;
    logic next_presence;
    logic next_detect_lamp;
    logic next_power_lamp;
    loop_fault_pkg::display_s next_display;
    logic next_retune;

    loop_fault_pkg::fault_e live_code;
    logic change_event;
    logic fault_live;
    logic onset;
    logic delaying;
    logic short_release;
    logic hold_reached;
    logic delay_done;
    logic retune_done;
    logic hold_done;
    logic outage_done;
    logic freq_done;
    logic blink_tick;
    logic live_lamp;
    logic mem_lamp;

    // fault classification; a change only counts above the limit [R4]
    assign change_event = i_loop.change_valid && (i_loop.change_pct > `CHANGE_LIMIT_PCT);
    always_comb begin
        if (i_loop.open_loop) begin
            live_code = loop_fault_pkg::FAULT_OPEN; // [R4]
        end else if (i_loop.short_loop) begin
            live_code = loop_fault_pkg::FAULT_SHORT; // [R4]
        end else if (change_latched || change_event) begin
            live_code = loop_fault_pkg::FAULT_CHANGE; // [R4]
        end else begin
            live_code = loop_fault_pkg::FAULT_NONE;
        end
    end
    assign fault_live = (live_code != loop_fault_pkg::FAULT_NONE);
    assign onset = fault_live && (live_code != prev_live);
    assign delaying = i_delay_enable && i_vehicle && !call && i_power_good;
    assign short_release = !i_button && btn_prev && !recall_taken;
    assign hold_reached = hold_done && !recall_taken;

    hold_timer #(.LIMIT(DELAY_CYCLES)) u_delay (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(delaying), .o_done(delay_done));
    hold_timer #(.LIMIT(RETUNE_CYCLES)) u_retune (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(change_latched), .o_done(retune_done));
    hold_timer #(.LIMIT(RECALL_CYCLES)) u_hold (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(i_button), .o_done(hold_done));
    hold_timer #(.LIMIT(OUTAGE_CYCLES)) u_outage (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(!i_power_good), .o_done(outage_done));
    hold_timer #(.LIMIT(FREQ_SHOW_CYCLES)) u_freq (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(freq_show), .o_done(freq_done));
    hold_timer #(.LIMIT(BLINK_CYCLES - 1)) u_blink (
        .i_clock(i_clock), .i_reset(i_reset), .i_run(delaying && !blink_tick),
        .o_done(blink_tick));

    // flash count equals the fault code position [R6]
    flash_sequencer #(
        .ON_CYCLES(FLASH_ON_CYCLES),
        .OFF_CYCLES(FLASH_OFF_CYCLES),
        .PAUSE_CYCLES(FLASH_PAUSE_CYCLES)
    ) u_live_seq (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_flashes(2'(live_code)),
        .o_lamp(live_lamp)
    );
    flash_sequencer #(
        .ON_CYCLES(FLASH_ON_CYCLES),
        .OFF_CYCLES(FLASH_OFF_CYCLES),
        .PAUSE_CYCLES(FLASH_PAUSE_CYCLES)
    ) u_mem_seq (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_flashes(2'(last_fault)),
        .o_lamp(mem_lamp)
    );

    // memory, button and tuning state
    always_comb begin
        next_boot = 1'b0;
        next_last_fault = last_fault;
        next_show_mem = show_mem;
        next_recall = recall;
        next_recall_taken = recall_taken;
        next_freq_show = freq_show && !freq_done;
        next_nv_we = 1'b0;
        next_nv_code = 2'(last_fault);
        next_retune = 1'b0;
        // retune once the change fault has stood its time [R8]
        next_change_latched = change_latched && !retune_done;
        if (retune_done && change_latched) begin
            next_retune = 1'b1; // [R8]
        end
        if (boot) begin
            // stored status comes back on the power lamp, none shows steady [R12]
            next_last_fault = loop_fault_pkg::fault_e'(i_nv_code);
            next_show_mem = 1'b1; // [R12]
            next_retune = 1'b1; // [R15]
            next_freq_show = 1'b1;
        end
        if (i_button && !btn_prev) begin
            next_recall = 1'b0;
            next_recall_taken = 1'b0;
        end
        if (hold_reached) begin
            // a long hold shows the record instead of clearing it [R10]
            next_recall_taken = 1'b1;
            next_recall = 1'b1;
            next_show_mem = 1'b1;
        end
        if (short_release) begin
            next_last_fault = loop_fault_pkg::FAULT_NONE; // [R13]
            next_nv_we = 1'b1; // [R13]
            next_nv_code = 2'(loop_fault_pkg::FAULT_NONE);
            next_show_mem = 1'b0; // [R9]
            next_freq_show = 1'b1; // [R9]
            next_retune = 1'b1; // [R9]
            next_change_latched = 1'b0;
        end
        // a new fault wins over a clear in the same cycle
        if (change_event) begin
            next_change_latched = 1'b1;
        end
        if (onset) begin
            next_last_fault = live_code; // [R11]
            next_nv_we = 1'b1; // [R11]
            next_nv_code = 2'(live_code);
            next_show_mem = 1'b1; // [R7]
        end
    end

    // vehicle call and delay
    always_comb begin
        next_call = call;
        if (!i_power_good) begin
            // hold the call through short outages only [R14]
            next_call = call && !outage_done;
        end else if (short_release || !i_vehicle) begin
            next_call = 1'b0; // [R16]
        end else if (!i_delay_enable || delay_done) begin
            next_call = 1'b1; // [R16]
        end
        next_blink = delaying ? (blink ^ blink_tick) : 1'b1;
    end

    // indicators and outputs; the second output has no lamp at all [R3]
    always_comb begin
        next_presence = call || (i_fail_safe && fault_live); // [R17]
        if (fault_live) begin
            next_detect_lamp = live_lamp; // [R5]
        end else if (delaying) begin
            next_detect_lamp = blink; // [R2]
        end else begin
            next_detect_lamp = call; // [R1]
        end
        if (fault_live) begin
            next_power_lamp = live_lamp; // [R5]
        end else if (show_mem) begin
            next_power_lamp = mem_lamp; // [R7]
        end else begin
            next_power_lamp = 1'b1;
        end
        if (fault_live) begin
            next_display.mode = loop_fault_pkg::DISP_FAULT; // [R5]
            next_display.value = {6'h00, 2'(live_code)}; // [R6]
        end else if (recall) begin
            next_display.mode = loop_fault_pkg::DISP_FAULT; // [R10]
            next_display.value = {6'h00, 2'(last_fault)};
        end else if (freq_show) begin
            next_display.mode = loop_fault_pkg::DISP_FREQ; // [R9]
            next_display.value = i_loop_freq_khz;
        end else if (delaying) begin
            next_display.mode = loop_fault_pkg::DISP_DELAY;
            next_display.value = `DISP_BLANK;
        end else begin
            next_display.mode = loop_fault_pkg::DISP_NORMAL;
            next_display.value = `DISP_BLANK;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            boot <= 1'b1;
            change_latched <= 1'b0;
            call <= 1'b0;
            show_mem <= 1'b0;
            recall <= 1'b0;
            recall_taken <= 1'b0;
            freq_show <= 1'b0;
            btn_prev <= 1'b0;
            blink <= 1'b1;
            last_fault <= loop_fault_pkg::FAULT_NONE;
            prev_live <= loop_fault_pkg::FAULT_NONE;
            o_nv_we <= 1'b0;
            o_nv_code <= 2'h0;
            o_presence <= 1'b0;
            o_detect_lamp <= 1'b0;
            o_power_lamp <= 1'b1;
            o_display <= '0;
            o_retune <= 1'b0;
        end else begin
            boot <= next_boot;
            change_latched <= next_change_latched;
            call <= next_call;
            show_mem <= next_show_mem;
            recall <= next_recall;
            recall_taken <= next_recall_taken;
            freq_show <= next_freq_show;
            btn_prev <= i_button;
            blink <= next_blink;
            last_fault <= next_last_fault;
            prev_live <= live_code;
            o_nv_we <= next_nv_we;
            o_nv_code <= next_nv_code;
            o_presence <= next_presence;
            o_detect_lamp <= next_detect_lamp;
            o_power_lamp <= next_power_lamp;
            o_display <= next_display;
            o_retune <= next_retune;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence s_heal;
        !fault_live && show_mem;
    endsequence

    a_steady_detect: assert property (!fault_live && !delaying && call |=> o_detect_lamp) // [R1]
        else $error("detect lamp not steady on call");
    a_delay_blink: assert property (delaying && !fault_live |=> o_detect_lamp == $past(blink)) // [R2]
        else $error("detect lamp not blinking in delay");
    a_fault_pair: assert property (fault_live |=> o_detect_lamp == o_power_lamp) // [R5]
        else $error("lamps not flashing together");
    a_fault_code: assert property (fault_live |=>
        o_display.mode == loop_fault_pkg::DISP_FAULT
        && o_display.value == {6'h00, 2'($past(live_code))}) // [R6]
        else $error("display code wrong");
    a_healed_lamp: assert property (s_heal |=> o_power_lamp == $past(mem_lamp)) // [R7]
        else $error("power lamp lost memory pattern");
    a_retune_pulse: assert property (retune_done && change_latched |=> // [R8]
        o_retune && (!change_latched || $past(change_event)))
        else $error("no retune after change fault");
    a_nv_store: assert property (onset |=> o_nv_we && o_nv_code == 2'($past(live_code))) // [R11]
        else $error("fault not written to store");
    a_momentary_clear: assert property (short_release && !onset |=>
        last_fault == loop_fault_pkg::FAULT_NONE && !show_mem && o_nv_we) // [R13]
        else $error("momentary press did not clear record");
    a_outage_hold: assert property (!i_power_good && !outage_done && call |=> call) // [R14]
        else $error("call dropped in short outage");
    a_delay_abort: assert property (i_delay_enable && !call && !delay_done |=> !call) // [R16]
        else $error("call before delay ran out");
    a_failsafe: assert property (fault_live && i_fail_safe |=> o_presence) // [R17]
        else $error("fail-safe presence missing");
    a_boot_tune: assert property (boot && !i_reset |=> o_retune && show_mem) // [R15]
        else $error("no tuning at power-up");
endmodule

//--- tb/gate_operator_model.sv
// gate operator model watching the open-collector presence line
`timescale 1ns/100ps

module gate_operator_model (
    // clock
    input wire logic i_clock,
    // call line: pulled up, pulled low while the detector calls
    input wire logic i_call_line_n,
    // observation
    output int o_opens
);
    logic last_n = 1'b1;
    int opens_seen = 0;

    assign o_opens = opens_seen;

    // one gate opening per new call; a call aborted inside the delay never reaches us
    always @(posedge i_clock) begin
        if (last_n && !i_call_line_n) opens_seen <= opens_seen + 1;
        last_n <= i_call_line_n;
    end
endmodule

//--- tb/loop_fault_indication_memory_tb_top.sv
// self-checking bench of the loop fault indication and memory block
`timescale 1ns/100ps

module loop_fault_indication_memory_tb_top;
    typedef struct packed {
        logic veh;
        logic opn;
        logic sht;
        logic fs;
        logic pres;
        logic [9:0] disp;
    } row_s;

    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_vehicle = 1'b0;
    logic i_delay_enable = 1'b0;
    logic i_fail_safe = 1'b0;
    logic i_button = 1'b0;
    logic i_power_good = 1'b1;
    loop_fault_pkg::loop_status_s loop_in = '0;
    logic [1:0] nv_store = 2'h0;
    logic [7:0] loop_freq = 8'h19;
    // shortened timings so every timer runs out within a few dozen cycles
    localparam int unsigned base_cycles = 20;
    localparam int unsigned recall_cycles = 30;
    localparam int unsigned blink_cycles = 4;
    localparam int unsigned flash_cycles = 3;
    localparam int unsigned pause_cycles = 10;
    logic o_nv_we, o_presence, o_detect_lamp, o_power_lamp, o_retune;
    logic [1:0] o_nv_code;
    loop_fault_pkg::display_s o_display;
    int opens, opens0, tog, bad_count = 0, cmp_count = 0;
    logic prev;
    row_s rows [5] = '{
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000},
        '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 10'h000},
        '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 10'h101},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 10'h102},
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000}};

    initial forever #10 i_clock = ~i_clock;

    // the store keeps whatever the block last wrote, across resets
    always @(posedge i_clock) if (o_nv_we) nv_store <= o_nv_code;

    loop_fault_indication_memory #(.DELAY_CYCLES(base_cycles), .RETUNE_CYCLES(base_cycles),
        .RECALL_CYCLES(recall_cycles), .OUTAGE_CYCLES(base_cycles),
        .FREQ_SHOW_CYCLES(base_cycles), .BLINK_CYCLES(blink_cycles),
        .FLASH_ON_CYCLES(flash_cycles), .FLASH_OFF_CYCLES(flash_cycles),
        .FLASH_PAUSE_CYCLES(pause_cycles)) u_dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_vehicle(i_vehicle), .i_loop(loop_in),
        .i_loop_freq_khz(loop_freq), .i_delay_enable(i_delay_enable), .i_fail_safe(i_fail_safe),
        .i_button(i_button), .i_power_good(i_power_good), .i_nv_code(nv_store),
        .o_nv_we(o_nv_we), .o_nv_code(o_nv_code), .o_presence(o_presence),
        .o_detect_lamp(o_detect_lamp), .o_power_lamp(o_power_lamp), .o_display(o_display),
        .o_retune(o_retune));

    // open collector: transistor on pulls the line low
    gate_operator_model u_gate (.i_clock(i_clock), .i_call_line_n(!o_presence), .o_opens(opens));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic go(input int v, o, s, fs, b, pg, de);
        @(posedge i_clock);
        i_vehicle <= v[0];
        loop_in.open_loop <= o[0];
        loop_in.short_loop <= s[0];
        i_fail_safe <= fs[0];
        i_button <= b[0];
        i_power_good <= pg[0];
        i_delay_enable <= de[0];
    endtask

    task automatic pulse_change(input logic [7:0] pct);
        @(posedge i_clock);
        loop_in.change_valid <= 1'b1;
        loop_in.change_pct <= pct;
        @(posedge i_clock);
        loop_in.change_valid <= 1'b0;
    endtask

    task automatic wait_retune(input int lim);
        int k = 0;
        while (o_retune !== 1'b1 && k <= lim) begin
            tick(1);
            k++;
        end
        check(k <= lim, 1'b1);
    endtask

    // groups are told apart by the long dark pause; short dark gaps separate flashes
    task automatic flashes(input logic [1:0] exp);
        int run = 0;
        int longs = 0;
        int n = 1;
        int k = 0;
        while (longs < 2 && k < 300) begin
            tick(1);
            k++;
            if (o_power_lamp !== 1'b1) run++;
            else begin
                if (run >= 10) longs++;
                else if (run > 0 && longs == 1) n++;
                run = 0;
            end
        end
        check(16'(longs == 2 ? n : 0), 16'(exp));
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(20 * 4000);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        wait_retune(4);
        for (int r = 0; r < 5; r++) begin
            go(rows[r].veh, rows[r].opn, rows[r].sht, rows[r].fs, 1'b0, 1'b1, 1'b0);
            tick(30);
            check(o_presence, rows[r].pres);
            check(o_display, rows[r].disp);
            if (rows[r].veh) check(o_detect_lamp, 1'b1);
            if (rows[r].opn || rows[r].sht) begin
                repeat (20) begin
                    tick(1);
                    check(o_detect_lamp, o_power_lamp);
                end
                flashes(rows[r].disp[1:0]);
            end
        end
        flashes(2'h2);
        check(nv_store, 2'h2);
        go(0, 0, 0, 0, 1, 1, 0);
        tick(35);
        go(0, 0, 0, 0, 0, 1, 0);
        tick(3);
        check(o_display, 10'h102);
        go(0, 0, 0, 0, 1, 1, 0);
        tick(2);
        go(0, 0, 0, 0, 0, 1, 0);
        tick(5);
        check(nv_store, 2'h0);
        check(o_display, 10'h219);
        repeat (40) begin
            tick(1);
            check(o_power_lamp, 1'b1);
        end
        pulse_change(8'h19);
        tick(5);
        check(o_display, 10'h000);
        pulse_change(8'h1A);
        tick(2);
        check(o_display, 10'h103);
        wait_retune(25);
        flashes(2'h3);
        // a power cycle: the stored change fault must come back on the power lamp
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        wait_retune(4);
        flashes(2'h3);
        opens0 = opens;
        go(1, 0, 0, 0, 0, 1, 1);
        tick(2);
        prev = o_detect_lamp;
        tog = 0;
        repeat (12) begin
            tick(1);
            if (o_detect_lamp !== prev) tog++;
            prev = o_detect_lamp;
        end
        check(o_presence, 1'b0);
        check(o_display, 10'h300);
        check(tog >= 2, 1'b1);
        go(0, 0, 0, 0, 0, 1, 1);
        tick(30);
        check(16'(opens), 16'(opens0));
        go(1, 0, 0, 0, 0, 1, 1);
        tick(30);
        check(o_presence, 1'b1);
        check(16'(opens), 16'(opens0 + 1));
        go(0, 0, 0, 0, 0, 0, 1);
        tick(10);
        check(o_presence, 1'b1);
        tick(20);
        check(o_presence, 1'b0);
        wrap_up();
    end
endmodule
